// file: src/upb_pkg.sv
package upb_pkg;
  // Register byte offsets
  localparam logic [11:0] DATA_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h018;
  localparam logic [11:0] LINE_OFS = 12'h02C;
  localparam logic [11:0] CTRL_OFS = 12'h030;
  // Control register field positions
  localparam int MODULE_ON_BIT = 0;
  localparam int LOOPBACK_BIT = 7;
  localparam int TX_ON_BIT = 8;
  localparam int RX_ON_BIT = 9;
  // Line register field positions
  localparam int BREAK_BIT = 0;
  localparam int PARITY_ON_BIT = 1;
  localparam int EVEN_BIT = 2;
  localparam int TWO_STOP_BIT = 3;
  // Values after reset
  localparam logic [31:0] CTRL_RESET = 32'h0000_0300;
  localparam logic [3:0] LINE_RESET = 4'h0;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int DATA_BITS = 8;
  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic rx_section_on;
    logic tx_section_on;
    logic loopback_on;
    logic module_on;
  } upb_ctl_type;

  typedef struct packed {
    logic two_stop_sel;
    logic even_parity_sel;
    logic parity_on;
    logic send_break;
  } upb_line_type;

  // Parity bit that makes data plus parity even (even=1) or odd (even=0)
  function automatic logic upb_parity(input logic [7:0] d, input logic even);
    return even ? ^d : ~^d;
  endfunction
endpackage

// file: src/upb_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module upb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("upb_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: src/upb_bit_timer.sv
`timescale 1ns/100ps
`default_nettype none
module upb_bit_timer #(
  parameter int CYCLES = upb_pkg::BIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic restart_half,
  output logic tick
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(CYCLES / 2);

  if (CYCLES < 4) begin : g_bad_cycles
    $error("upb_bit_timer needs at least 4 cycles per bit");
  end

  logic [CW-1:0] cnt;

  // One-cycle enable pulse per bit period; idle counter held at zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (restart_half) begin
      cnt <= HALF;
      tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: src/upb_serial_ctrl.sv
// What this block does
// - Even select gives even ones over data plus parity; cleared gives odd.
// - Even select is ignored while parity is off.
// - Parity on adds a parity bit on send and checks it on receive.
// - Send break finishes the current character, then holds the output low.
// - Control register resets to zero except transmit and receive enables set.
// - Nothing runs until the module enable is written to one.
// - Disabling mid-character lets that character finish first.
// - Two stop bits are sent when selected; the receiver checks only one.
// - Receiver runs only with receive enable; clearing it lets the character finish.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module upb_serial_ctrl #(
  parameter int BIT_CYCLES = upb_pkg::BIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic tx_fifo_ready
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_BREAK} upb_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} upb_rx_state_type;

  upb_pkg::upb_ctl_type ctl;
  upb_pkg::upb_line_type line;
  upb_tx_state_type tx_state;
  upb_rx_state_type rx_state;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] tx_shift;
  logic [2:0] tx_idx;
  logic tx_stop_idx;
  logic tx_par;
  logic tx_tick;
  logic tx_go;
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  logic rx_line;
  logic rx_tick;
  logic rx_start_seen;
  logic [7:0] rx_shift;
  logic [2:0] rx_idx;
  logic rx_par_bad;
  logic [7:0] rx_data;
  logic rx_full;
  logic parity_err;
  logic frame_err;
  logic data_wr;
  logic data_rd;
  logic rx_done;

  // Register decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  assign data_wr = reg_wr && hit(reg_addr, upb_pkg::DATA_OFS);
  assign data_rd = reg_rd && hit(reg_addr, upb_pkg::DATA_OFS);

  // Control register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctl.module_on <= upb_pkg::CTRL_RESET[upb_pkg::MODULE_ON_BIT];
      ctl.loopback_on <= upb_pkg::CTRL_RESET[upb_pkg::LOOPBACK_BIT];
      ctl.tx_section_on <= upb_pkg::CTRL_RESET[upb_pkg::TX_ON_BIT];
      ctl.rx_section_on <= upb_pkg::CTRL_RESET[upb_pkg::RX_ON_BIT];
    end else if (reg_wr && hit(reg_addr, upb_pkg::CTRL_OFS)) begin
      ctl.module_on <= reg_wdata[upb_pkg::MODULE_ON_BIT];
      ctl.loopback_on <= reg_wdata[upb_pkg::LOOPBACK_BIT];
      ctl.tx_section_on <= reg_wdata[upb_pkg::TX_ON_BIT];
      ctl.rx_section_on <= reg_wdata[upb_pkg::RX_ON_BIT];
    end
  end

  // Line register: break, parity and stop bit selection
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      line <= upb_pkg::LINE_RESET;
    end else if (reg_wr && hit(reg_addr, upb_pkg::LINE_OFS)) begin
      line.send_break <= reg_wdata[upb_pkg::BREAK_BIT];
      line.parity_on <= reg_wdata[upb_pkg::PARITY_ON_BIT];
      line.even_parity_sel <= reg_wdata[upb_pkg::EVEN_BIT];
      line.two_stop_sel <= reg_wdata[upb_pkg::TWO_STOP_BIT];
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (hit(reg_addr, upb_pkg::CTRL_OFS)) begin
      reg_rdata <= {22'h00_0000, ctl.rx_section_on, ctl.tx_section_on, ctl.loopback_on, 6'h00, ctl.module_on};
    end else if (hit(reg_addr, upb_pkg::LINE_OFS)) begin
      reg_rdata <= {28'h000_0000, line};
    end else if (hit(reg_addr, upb_pkg::STAT_OFS)) begin
      reg_rdata <= {25'h000_0000, rx_state != RX_IDLE, tx_state == TX_BREAK, frame_err, parity_err,
                    rx_full, tx_state != TX_IDLE, !fifo_in_ready};
    end else if (hit(reg_addr, upb_pkg::DATA_OFS)) begin
      reg_rdata <= {24'h00_0000, rx_data};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Transmit FIFO; writes to a full FIFO are dropped
  upb_fifo #(.WIDTH(upb_pkg::DATA_BITS), .DEPTH(upb_pkg::FIFO_DEPTH)) u_tx_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(data_wr),
    .in_ready(fifo_in_ready),
    .in_data(reg_wdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Registered space indication for the writer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_fifo_ready <= 1'b0;
    end else begin
      tx_fifo_ready <= fifo_in_ready;
    end
  end

  assign tx_go = ctl.module_on && ctl.tx_section_on;
  assign fifo_out_ready = (tx_state == TX_IDLE) && tx_go && !line.send_break;

  upb_bit_timer #(.CYCLES(BIT_CYCLES)) u_tx_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(tx_state != TX_IDLE && tx_state != TX_BREAK),
    .restart_half(1'b0),
    .tick(tx_tick)
  );

  // Transmit sequencer; once started a character always completes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_state <= TX_IDLE;
      tx_shift <= 8'h00;
      tx_idx <= 3'h0;
      tx_stop_idx <= 1'b0;
      tx_par <= 1'b0;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          if (line.send_break && ctl.module_on) begin
            tx_state <= TX_BREAK;
          end else if (fifo_out_valid && fifo_out_ready) begin
            tx_shift <= fifo_out_data;
            tx_par <= upb_pkg::upb_parity(fifo_out_data, line.even_parity_sel);
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          if (tx_tick) begin
            tx_state <= TX_DATA;
            tx_idx <= 3'h0;
          end
        end
        TX_DATA: begin
          if (tx_tick) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_idx <= tx_idx + 1'b1;
            if (tx_idx == 3'h7) begin
              tx_stop_idx <= 1'b0;
              tx_state <= line.parity_on ? TX_PARITY : TX_STOP;
            end
          end
        end
        TX_PARITY: begin
          if (tx_tick) begin
            tx_state <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            if (line.two_stop_sel && !tx_stop_idx) begin
              tx_stop_idx <= 1'b1;
            end else begin
              tx_state <= TX_IDLE;
            end
          end
        end
        TX_BREAK: begin
          if (!line.send_break) begin
            tx_state <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Serial output driven from a flop; break forces it low
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      serial_out_pin <= 1'b1;
    end else begin
      unique case (tx_state)
        TX_START: serial_out_pin <= 1'b0;
        TX_DATA: serial_out_pin <= tx_shift[0];
        TX_PARITY: serial_out_pin <= tx_par;
        TX_BREAK: serial_out_pin <= 1'b0;
        default: serial_out_pin <= 1'b1;
      endcase
    end
  end

  // Input synchroniser and loop-back selection
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= serial_in_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_line;
    end
  end

  assign rx_line = ctl.loopback_on ? serial_out_pin : rx_sync;
  assign rx_start_seen = (rx_state == RX_IDLE) && ctl.module_on && ctl.rx_section_on && rx_prev && !rx_line;
  assign rx_done = (rx_state == RX_STOP) && rx_tick;

  upb_bit_timer #(.CYCLES(BIT_CYCLES)) u_rx_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(rx_state != RX_IDLE || rx_start_seen), // Armed on the start edge so the half-bit preload takes
    .restart_half(rx_start_seen),
    .tick(rx_tick)
  );

  // Receive sequencer, sampling at mid-bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_state <= RX_IDLE;
      rx_shift <= 8'h00;
      rx_idx <= 3'h0;
      rx_par_bad <= 1'b0;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          rx_par_bad <= 1'b0;
          if (rx_start_seen) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_idx <= 3'h0;
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_idx <= rx_idx + 1'b1;
            if (rx_idx == 3'h7) begin
              rx_state <= line.parity_on ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rx_tick) begin
            rx_par_bad <= rx_line != upb_pkg::upb_parity(rx_shift, line.even_parity_sel);
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive holding register and error flags; a new character wins over the read clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
      parity_err <= 1'b0;
      frame_err <= 1'b0;
    end else if (rx_done) begin
      rx_data <= rx_shift;
      rx_full <= 1'b1;
      parity_err <= rx_par_bad;
      frame_err <= !rx_line;
    end else if (data_rd) begin
      rx_full <= 1'b0;
      parity_err <= 1'b0;
      frame_err <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_break_asked;
    tx_state == TX_IDLE && line.send_break && ctl.module_on;
  endsequence
  sequence s_line_low_held;
    tx_state == TX_BREAK ##1 !serial_out_pin;
  endsequence

  chk_reset_values: assert property ($past(sys_rst) |-> ctl == 4'b1100 && line == 4'h0)
    else $error("control register reset value wrong");
  chk_break_low: assert property (s_break_asked |=> s_line_low_held)
    else $error("break did not drive the line low");
  chk_idle_off: assert property (tx_state == TX_IDLE && !ctl.module_on |=> tx_state == TX_IDLE)
    else $error("transmitter left idle while disabled");
  chk_rx_off: assert property (rx_state == RX_IDLE && !ctl.rx_section_on |=> rx_state == RX_IDLE)
    else $error("receiver started while disabled");
  chk_parity_value: assert property (tx_state == TX_PARITY |=> serial_out_pin == tx_par)
    else $error("parity bit value wrong on line");
  chk_parity_skip: assert property (tx_state == TX_DATA && tx_tick && tx_idx == 3'h7 && !line.parity_on
    |=> tx_state == TX_STOP)
    else $error("parity bit sent while parity off");
  chk_parity_place: assert property (tx_state == TX_DATA && tx_tick && tx_idx == 3'h7 && line.parity_on
    |=> tx_state == TX_PARITY)
    else $error("parity bit not after last data bit");
  chk_two_stop: assert property (tx_state == TX_STOP && tx_tick && !tx_stop_idx && line.two_stop_sel
    |=> tx_state == TX_STOP)
    else $error("second stop bit missing");
  chk_finish_char: assert property ($fell(ctl.module_on) && tx_state == TX_DATA |-> tx_state != TX_IDLE [*2])
    else $error("character cut short on disable");
endmodule
`default_nettype wire

// file: dv/upb_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
// Remote serial transceiver at the far end of the line
module upb_peer_model #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic line_in,
  output logic line_out
);
  logic [10:0] rx_bits;
  int frame_count;
  logic prev_level;

  // Line idles high
  initial begin
    line_out = 1'b1;
    rx_bits = '0;
    frame_count = 0;
    prev_level = 1'b1;
  end

  // Start bit, then nbits frame bits LSB first, then back to idle
  task automatic send_frame(input logic [10:0] bits, input int nbits);
    @(posedge ref_clk);
    line_out <= 1'b0;
    repeat (BIT_CYCLES) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      line_out <= bits[i];
      repeat (BIT_CYCLES) @(posedge ref_clk);
    end
    line_out <= 1'b1;
  endtask

  // Samples eleven cells mid-bit after a falling edge; negedge avoids racing the driver
  always begin
    @(negedge ref_clk);
    if (prev_level && !line_in) begin
      repeat (BIT_CYCLES / 2) @(negedge ref_clk);
      for (int i = 0; i < 11; i++) begin
        repeat (BIT_CYCLES) @(negedge ref_clk);
        rx_bits[i] = line_in;
      end
      frame_count++;
    end
    prev_level = line_in;
  end
endmodule
`default_nettype wire

// file: dv/test_uart_parity_break_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_uart_parity_break_control;
  localparam int BIT = 8;
  logic ref_clk;
  logic sys_rst;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic peer_line;
  logic serial_out_pin;
  logic tx_fifo_ready;
  logic [31:0] rd;
  int mismatches;
  int cmp_count;

  upb_serial_ctrl #(.BIT_CYCLES(BIT)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(peer_line),
    .serial_out_pin(serial_out_pin), .tx_fifo_ready(tx_fifo_ready)
  );

  upb_peer_model #(.BIT_CYCLES(BIT)) i_peer (
    .ref_clk(ref_clk), .line_in(serial_out_pin), .line_out(peer_line)
  );

  // Clock, 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Waits, bounded, for the peer to have caught target frames
  task automatic wait_frame(input int target);
    for (int i = 0; i < 3000 && i_peer.frame_count < target; i++) @(posedge ref_clk);
    check("frame count", i_peer.frame_count, target);
  endtask

  // Disable, rewrite line settings, enable
  task automatic configure(input logic [31:0] line, input logic [31:0] ctrl);
    reg_write(upb_pkg::CTRL_OFS, 32'h0000_0300);
    reg_write(upb_pkg::LINE_OFS, line);
    reg_write(upb_pkg::CTRL_OFS, ctrl);
  endtask

  task automatic test_reset;
    reg_read(upb_pkg::CTRL_OFS, rd);
    check("control after reset", rd, 32'h0000_0300);
    reg_read(upb_pkg::LINE_OFS, rd);
    check("line after reset", rd, 32'h0000_0000);
    reg_write(12'h004, 32'hFFFF_FFFF);
    reg_read(12'h004, rd);
    check("unmapped read", rd, 32'h0000_0000);
    reg_write(upb_pkg::CTRL_OFS, 32'hFFFF_FC7E);
    reg_read(upb_pkg::CTRL_OFS, rd);
    check("reserved control bits", rd, 32'h0000_0000);
    reg_write(upb_pkg::CTRL_OFS, 32'h0000_0300);
    $display("done: reset values");
  endtask

  task automatic test_fifo_fill;
    int n;
    int base;
    n = 0;
    base = i_peer.frame_count;
    reg_write(upb_pkg::LINE_OFS, 32'h0000_000E);
    while (tx_fifo_ready === 1'b1 && n < 8) begin
      reg_write(upb_pkg::DATA_OFS, 32'h10 + n);
      n++;
      repeat (3) @(posedge ref_clk);
    end
    check("bytes accepted", n, 4);
    reg_read(upb_pkg::STAT_OFS, rd);
    check("fifo full status", rd[0], 1'b1);
    repeat (300) @(posedge ref_clk);
    check("frames while off", i_peer.frame_count, base);
    reg_write(upb_pkg::CTRL_OFS, 32'h0000_0301);
    wait_frame(base + 4);
    check("last byte", i_peer.rx_bits[7:0], 8'h13);
    check("even parity bit", i_peer.rx_bits[8], ^8'h13);
    check("second stop", i_peer.rx_bits[10:9], 2'b11);
    check("space after drain", tx_fifo_ready, 1'b1);
    $display("done: fifo fill and drain");
  endtask

  task automatic test_parity_tx;
    for (int e = 0; e < 2; e++) begin
      for (int p = 0; p < 2; p++) begin
        configure(32'(e * 4 + p * 2), 32'h0000_0301);
        reg_write(upb_pkg::DATA_OFS, 32'h0000_0080);
        wait_frame(i_peer.frame_count + 1);
        check("data bits", i_peer.rx_bits[7:0], 8'h80);
        check("bit after data", i_peer.rx_bits[8], p ? e[0] : 1'b1);
        check("stop bit", i_peer.rx_bits[9], 1'b1);
        repeat (4) @(posedge ref_clk);
      end
    end
    $display("done: parity on send");
  endtask

  task automatic test_parity_rx;
    configure(32'h0000_0006, 32'h0000_0301);
    i_peer.send_frame({2'b11, ^8'h5A, 8'h5A}, 11);
    repeat (10) @(posedge ref_clk);
    reg_read(upb_pkg::STAT_OFS, rd);
    check("good parity flags", rd[3:2], 2'b01);
    check("good stop flag", rd[4], 1'b0);
    reg_read(upb_pkg::DATA_OFS, rd);
    check("received byte", rd, 32'h0000_005A);
    i_peer.send_frame({2'b11, ~^8'h5A, 8'h5A}, 11);
    repeat (10) @(posedge ref_clk);
    reg_read(upb_pkg::STAT_OFS, rd);
    check("bad parity flag", rd[3], 1'b1);
    reg_read(upb_pkg::DATA_OFS, rd);
    // First stop bit low, second high: only the first one is judged
    i_peer.send_frame({2'b10, ^8'h5A, 8'h5A}, 11);
    repeat (10) @(posedge ref_clk);
    reg_read(upb_pkg::STAT_OFS, rd);
    check("stop error flags", rd[4:2], 3'b101);
    reg_read(upb_pkg::DATA_OFS, rd);
    $display("done: parity on receive");
  endtask

  task automatic test_rx_off;
    configure(32'h0000_0000, 32'h0000_0101);
    i_peer.send_frame({2'b11, 9'h1C3}, 10);
    repeat (10) @(posedge ref_clk);
    reg_read(upb_pkg::STAT_OFS, rd);
    check("receiver off", rd[2], 1'b0);
    reg_write(upb_pkg::CTRL_OFS, 32'h0000_0100);
    reg_write(upb_pkg::CTRL_OFS, 32'h0000_0301);
    $display("done: receiver off");
  endtask

  task automatic test_break;
    configure(32'h0000_0000, 32'h0000_0301);
    reg_write(upb_pkg::DATA_OFS, 32'h0000_00FF);
    repeat (2 * BIT) @(posedge ref_clk);
    reg_write(upb_pkg::LINE_OFS, 32'h0000_0001);
    wait_frame(i_peer.frame_count + 1);
    check("byte before break", i_peer.rx_bits[8:0], 9'h1FF);
    // Hold the break for twenty bit periods, two ten-bit character periods
    for (int i = 0; i < 4; i++) begin
      repeat (5 * BIT) @(posedge ref_clk);
      check("line in break", serial_out_pin, 1'b0);
    end
    reg_read(upb_pkg::STAT_OFS, rd);
    check("break status", rd[5], 1'b1);
    check("busy in break", rd[1], 1'b1);
    reg_write(upb_pkg::LINE_OFS, 32'h0000_0000);
    repeat (4) @(posedge ref_clk);
    check("line after break", serial_out_pin, 1'b1);
    $display("done: send break");
  endtask

  task automatic test_disable_mid;
    reg_write(upb_pkg::DATA_OFS, 32'h0000_003C);
    repeat (3 * BIT) @(posedge ref_clk);
    reg_write(upb_pkg::CTRL_OFS, 32'h0000_0300);
    wait_frame(i_peer.frame_count + 1);
    check("finished byte", i_peer.rx_bits[8:0], 9'h13C);
    reg_write(upb_pkg::DATA_OFS, 32'h0000_0042);
    repeat (200) @(posedge ref_clk);
    check("held while off", serial_out_pin, 1'b1);
    reg_write(upb_pkg::CTRL_OFS, 32'h0000_0301);
    wait_frame(i_peer.frame_count + 1);
    check("queued byte", i_peer.rx_bits[7:0], 8'h42);
    $display("done: disable mid character");
  endtask

  task automatic test_loopback;
    reg_write(upb_pkg::CTRL_OFS, 32'h0000_0300);
    reg_write(upb_pkg::CTRL_OFS, 32'h0000_0381);
    reg_write(upb_pkg::DATA_OFS, 32'h0000_00A5);
    repeat (15 * BIT) @(posedge ref_clk);
    reg_read(upb_pkg::DATA_OFS, rd);
    check("looped byte", rd, 32'h0000_00A5);
    $display("done: loopback");
  endtask

  // Single place where the run ends
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end

  // Reset, then the scenarios in turn
  initial begin
    mismatches = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    test_reset();
    test_fifo_fill();
    test_parity_tx();
    test_parity_rx();
    test_rx_off();
    test_break();
    test_disable_mid();
    test_loopback();
    print_verdict();
  end
endmodule
`default_nettype wire
